/* rtl/ppfs_regs.vh */
/*
 * register map and field layout of the port pin function select block.
 * assumes a 32-bit apb slave with one aligned word per register.
 */
`ifndef PPFS_REGS_VH
`define PPFS_REGS_VH

// ==========================================================================
// register byte offsets
`define PPFS_OFF_PA_DIR     12'h000
`define PPFS_OFF_PA_FSEL1   12'h004
`define PPFS_OFF_PA_FSEL2   12'h008
`define PPFS_OFF_PB_DIR     12'h00c

// ==========================================================================
// writable bit masks
`define PPFS_MASK_PA_DIR    16'h03ff
`define PPFS_MASK_PA_FSEL1  16'h0005
`define PPFS_MASK_PA_FSEL2  16'h5555
`define PPFS_MASK_PB_DIR    16'h3fff

// ==========================================================================
// reset values
`define PPFS_RST_16         16'h0000

// ==========================================================================
// field positions
`define PPFS_FSEL1_PIN25    2
`define PPFS_FSEL1_PIN24    0
// pin indices on the port a pin vectors: pin 25 at the top, pin 16 at zero
`define PPFS_IDX_PIN25      9
`define PPFS_IDX_PIN24      8
`define PPFS_FSEL2_PINS     8
`define PPFS_REG_W          16

`endif

/* rtl/ppfs_reg16.v */
/*
 * one 16-bit software register whose reserved bits are masked.
 * assumes a synchronous write strobe in the pclk domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ppfs_regs.vh"

module ppfs_reg16 #(
  parameter [15:0] WMASK = 16'hffff
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // write side
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  // stored value
  output reg  [15:0] value_reg
);

  // ==========================================================================
  // storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg <= `PPFS_RST_16;
    end else if (wr_en) begin
      value_reg <= wr_data & WMASK;
    end
  end

endmodule
`default_nettype wire

/* rtl/ppfs_top.v */
/*
 * port pin function select: direction and function control for
 * port a pins 25..16 and direction control only for port b pins 13..0, reached over apb.
 * assumes the pin pads combine the output enables with pin data, and
 * that the external bus controller supplies address lines 25..16.
 */
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ppfs_regs.vh"

module ppfs_top #(
  parameter PA_PINS = 10,
  parameter PB_PINS = 14
) (
  // clock and reset
  input  wire               pclk,
  input  wire               presetn,
  // apb slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [11:0]        paddr,
  input  wire [31:0]        pwdata,
  input  wire [3:0]         pstrb,
  output reg  [31:0]        prdata,
  output reg                pready,
  output reg                pslverr,
  // port a pins 25..16
  input  wire [PA_PINS-1:0] pa_gpio_out,
  input  wire [PA_PINS-1:0] pa_bus_addr,
  output reg  [PA_PINS-1:0] pa_pin_out,
  output reg  [PA_PINS-1:0] pa_pin_oe_n,
  output reg  [PA_PINS-1:0] pa_alt_sel,
  // port b pins 13..0
  input  wire [PB_PINS-1:0] pb_gpio_out,
  output reg  [PB_PINS-1:0] pb_pin_out,
  output reg  [PB_PINS-1:0] pb_pin_oe_n
);

  // ==========================================================================
  // bus decode
  wire        setup_ph;
  wire        wr_fire;
  wire        hit_pa_dir;
  wire        hit_fsel1;
  wire        hit_fsel2;
  wire        hit_pb_dir;
  wire        hit_any;
  wire [15:0] wr_val;
  wire [15:0] pa_dir_q;
  wire [15:0] fsel1_q;
  wire [15:0] fsel2_q;
  wire [15:0] pb_dir_q;
  reg  [15:0] rd_mux;
  reg  [PA_PINS-1:0] pa_alt;

  // answer in the access cycle: setup is registered, pready rises for one edge
  assign setup_ph   = psel & ~penable;
  assign hit_pa_dir = (paddr == `PPFS_OFF_PA_DIR);
  assign hit_fsel1  = (paddr == `PPFS_OFF_PA_FSEL1);
  assign hit_fsel2  = (paddr == `PPFS_OFF_PA_FSEL2);
  assign hit_pb_dir = (paddr == `PPFS_OFF_PB_DIR);
  assign hit_any    = hit_pa_dir | hit_fsel1 | hit_fsel2 | hit_pb_dir;
  assign wr_fire    = psel & penable & pready & pwrite & hit_any;
  // only the low halfword lanes carry register bits
  assign wr_val     = {(pstrb[1] ? pwdata[15:8] : rd_mux[15:8]),
                       (pstrb[0] ? pwdata[7:0]  : rd_mux[7:0])};

  // ==========================================================================
  // registers
  ppfs_reg16 #(.WMASK(`PPFS_MASK_PA_DIR)) u_pa_dir (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (wr_fire & hit_pa_dir),
    .wr_data   (wr_val),
    .value_reg (pa_dir_q)
  );

  ppfs_reg16 #(.WMASK(`PPFS_MASK_PA_FSEL1)) u_fsel1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (wr_fire & hit_fsel1),
    .wr_data   (wr_val),
    .value_reg (fsel1_q)
  );

  ppfs_reg16 #(.WMASK(`PPFS_MASK_PA_FSEL2)) u_fsel2 (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (wr_fire & hit_fsel2),
    .wr_data   (wr_val),
    .value_reg (fsel2_q)
  );

  ppfs_reg16 #(.WMASK(`PPFS_MASK_PB_DIR)) u_pb_dir (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (wr_fire & hit_pb_dir),
    .wr_data   (wr_val),
    .value_reg (pb_dir_q)
  );

  // ==========================================================================
  // read mux
  always @* begin
    rd_mux = `PPFS_RST_16;
    if (hit_pa_dir) begin
      rd_mux = pa_dir_q;
    end else if (hit_fsel1) begin
      rd_mux = fsel1_q;
    end else if (hit_fsel2) begin
      rd_mux = fsel2_q;
    end else if (hit_pb_dir) begin
      rd_mux = pb_dir_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit_any;
      if (setup_ph & ~pwrite) begin
        prdata <= {16'h0000, rd_mux};
      end else if (!setup_ph) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // pin function decode: pin 25 at index 9 down to pin 16 at index 0
  integer i;
  always @* begin
    pa_alt = {PA_PINS{1'b0}};
    pa_alt[`PPFS_IDX_PIN25] = fsel1_q[`PPFS_FSEL1_PIN25];
    pa_alt[`PPFS_IDX_PIN24] = fsel1_q[`PPFS_FSEL1_PIN24];
    for (i = 0; i < `PPFS_FSEL2_PINS; i = i + 1) begin
      pa_alt[i] = fsel2_q[2*i];
    end
  end

  // ==========================================================================
  // pad drive, registered so every output comes from a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_pin_out  <= {PA_PINS{1'b0}};
      pa_pin_oe_n <= {PA_PINS{1'b1}};
      pa_alt_sel  <= {PA_PINS{1'b0}};
      pb_pin_out  <= {PB_PINS{1'b0}};
      pb_pin_oe_n <= {PB_PINS{1'b1}};
    end else begin
      pa_alt_sel  <= pa_alt;
      // address lines always drive; direction bit ignored in alternate mode
      pa_pin_out  <= (pa_alt & pa_bus_addr) | (~pa_alt & pa_gpio_out);
      pa_pin_oe_n <= ~(pa_alt | pa_dir_q[PA_PINS-1:0]);
      // port b alternate selects live elsewhere, so general i/o is assumed
      pb_pin_out  <= pb_gpio_out;
      pb_pin_oe_n <= ~pb_dir_q[PB_PINS-1:0];
    end
  end

endmodule
`default_nettype wire

/* verif/ppfs_pins.sv */
/* far-side pin sources: general output data and bus address lines.
   assumes one free-running pclk; pattern changes every cycle. */
`timescale 1ns/10ps
`default_nettype none
module ppfs_pins (
  // clock
  input  wire logic        pclk,
  // pin sources
  output wire logic [9:0]  pa_gpio_out,
  output wire logic [9:0]  pa_bus_addr,
  output wire logic [13:0] pb_gpio_out
);
  logic [13:0] cnt_reg = 14'h1555;
  // a new value each cycle so a stale pin sample never matches
  always @(posedge pclk) cnt_reg <= cnt_reg + 14'h0123;
  assign pa_gpio_out = cnt_reg[9:0];
  assign pa_bus_addr = ~cnt_reg[13:4];
  assign pb_gpio_out = cnt_reg ^ 14'h2aaa;
endmodule
`default_nettype wire

/* verif/ppfs_chk_assertions.sv */
/* apb and pin checks on ppfs_top ports.
   assumes it is bound onto ppfs_top. */
`timescale 1ns/10ps
`default_nettype none
module ppfs_chk #(parameter PA_PINS = 10, parameter PB_PINS = 14) (
  // apb
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  // pins
  input wire logic [PA_PINS-1:0] pa_gpio_out,
  input wire logic [PA_PINS-1:0] pa_bus_addr,
  input wire logic [PA_PINS-1:0] pa_pin_out,
  input wire logic [PA_PINS-1:0] pa_pin_oe_n,
  input wire logic [PA_PINS-1:0] pa_alt_sel,
  input wire logic [PB_PINS-1:0] pb_gpio_out,
  input wire logic [PB_PINS-1:0] pb_pin_out,
  input wire logic [PB_PINS-1:0] pb_pin_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // properties
  sequence s_setup; psel && !penable; endsequence
  sequence s_rd; pready && !pwrite; endsequence
  property p_ready; s_setup |=> pready && penable; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_dira; s_rd and paddr == 12'h000 |-> prdata[31:10] == 0; endproperty
  a_dira: assert property (p_dira) else $error("dir a reserved set");
  property p_sel1; s_rd and paddr == 12'h004 |-> (prdata & ~32'h5) == 0; endproperty
  a_sel1: assert property (p_sel1) else $error("sel1 reserved set");
  property p_sel2; s_rd and paddr == 12'h008 |-> (prdata & ~32'h5555) == 0; endproperty
  a_sel2: assert property (p_sel2) else $error("sel2 odd bit set");
  property p_dirb; s_rd and paddr == 12'h00c |-> prdata[31:14] == 0; endproperty
  a_dirb: assert property (p_dirb) else $error("dir b reserved set");
  property p_altoe; (pa_pin_oe_n & pa_alt_sel) == 0; endproperty
  a_altoe: assert property (p_altoe) else $error("alt pin not driven");
  property p_altd; ((pa_pin_out ^ $past(pa_bus_addr)) & pa_alt_sel) == 0; endproperty
  a_altd: assert property (p_altd) else $error("alt pin data wrong");
  // general i/o pins carry the port data one edge late; skip the first edge out of reset
  property p_gpd;
    $past(presetn) |-> ((pa_pin_out ^ $past(pa_gpio_out)) & ~pa_alt_sel) == 0;
  endproperty
  a_gpd: assert property (p_gpd) else $error("port a data wrong");
  property p_pbd; $past(presetn) |-> pb_pin_out == $past(pb_gpio_out); endproperty
  a_pbd: assert property (p_pbd) else $error("port b data wrong");
  property p_rst; $rose(presetn) |-> &pa_pin_oe_n && &pb_pin_oe_n && !pa_alt_sel; endproperty
  a_rst: assert property (p_rst) else $error("pins not inputs");
endmodule
bind ppfs_top ppfs_chk #(.PA_PINS(PA_PINS), .PB_PINS(PB_PINS)) u_chk (.*);
`default_nettype wire

/* verif/tb_top.sv */
/* bench for ppfs_top: apb register table, pin modes, reset.
   assumes ppfs_pins drives the pin sources. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0, ra[4];
  logic [31:0] pwdata = 0, prdata, rd, re[4];
  logic        pready, pslverr, er;
  logic [3:0]  pstrb = 4'h3;
  logic [9:0]  pa_gpio_out, pa_bus_addr, pa_pin_out, pa_pin_oe_n, pa_alt_sel;
  logic [13:0] pb_gpio_out, pb_pin_out, pb_pin_oe_n;
  int          miscompares = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  ppfs_top dut (.*);
  ppfs_pins u_pins (.*);
  // ==========
  // tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 50);
    // a wait that runs out is counted here as a mismatch
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    repeat (3000) @(posedge pclk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    ra = '{12'h000, 12'h004, 12'h008, 12'h00c};
    re = '{32'h03ff, 32'h0005, 32'h5555, 32'h3fff};
    repeat (4) @(posedge pclk);
    presetn <= 1;
    foreach (ra[i]) begin
      apb(1, ra[i], 32'hffff_ffff);
      apb(0, ra[i], 0);
      chk("reg", re[i], rd);
    end
    repeat (2) @(posedge pclk);
    chk("pa_oe", 0, pa_pin_oe_n);
    chk("alt", 32'h3ff, pa_alt_sel);
    chk("pb_oe", 0, pb_pin_oe_n);
    $display("register table done");
    apb(1, 12'h004, 32'h4);
    apb(1, 12'h008, 32'h1);
    pstrb <= 4'h1;
    apb(1, 12'h000, 32'h0);
    pstrb <= 4'h3;
    apb(0, 12'h000, 0);
    chk("strobe", 32'h300, rd);
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h00c, 32'h2);
    repeat (2) @(posedge pclk);
    chk("alt", 32'h201, pa_alt_sel);
    chk("pa_oe", 32'h1fe, pa_pin_oe_n);
    chk("pb_oe", 32'h3ffd, pb_pin_oe_n);
    apb(0, 12'h010, 0);
    chk("err", 1, er);
    chk("unmapped", 0, rd);
    $display("pin modes done");
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      chk("rst", 0, rd);
    end
    chk("pa_oe", 32'h3ff, pa_pin_oe_n);
    $display("reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
